// *** adcseq_core.sv ***
`timescale 1ns/10ps
// Overview of operation
// - run bit keeps software-mode conversions repeating
// - mode or channel write restarts conversion
// - reset clears result register
// - code is rounded vin over vref
// - one channel converted; pin or software start
// - trigger on rise, fall or both
// - result stored with done request together
// - trigger mode waits for valid edge
// - trigger mode: one conversion per edge
// - trigger mode write aborts, waits edge
// - write with run clear stops
// - software mode starts immediately
// - software mode repeats same channel
// - channel rewrite restarts new channel
// - halt in idle/stop, run in halt
// - result read wins over result write
// - trigger edges ignored while converting
// - write on the done cycle may corrupt
// - channel change keeps done flag
// - ten-bit approximation from msb
// - edge field: none, fall, rise, both
// - stabilization only when comparator off
module adcseq_core
   import adcseq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mode_wr,
   input wire logic [7:0] mode_wdata,
   input wire logic chsel_wr,
   input wire logic [3:0] chsel_wdata,
   input wire logic ref_wr,
   input wire logic ref_wdata,
   input wire logic result_rd,
   input wire logic flag_clr,
   input wire logic irq_ack,
   input wire logic standby_stop,
   input wire logic ext_trigger_pin,
   input wire logic comp_gt,
   output logic [7:0] conv_mode_reg,
   output logic [3:0] channel_select_reg,
   output logic [9:0] conv_result_reg,
   output logic conv_done_flag,
   output logic conv_done_irq,
   output logic conv_busy,
   output logic [9:0] dac_code,
   output logic [3:0] analog_mux_sel,
   output logic sample_hold,
   output logic comparator_off,
   output logic ref_switch_connect
);
   adcseq_state_t st_q, st_d;
   logic [7:0] mode_q, mode_d;
   logic [3:0] ch_q, ch_d;
   logic [9:0] sar_q, sar_d;
   logic [9:0] bit_q, bit_d;
   logic [9:0] res_q, res_d;
   logic [9:0] pend_q, pend_d;
   logic pend_v_q, pend_v_d;
   logic flag_q, flag_d;
   logic irq_d;
   logic trig_q, ref_q, ref_d;
   logic tmr_restart, tick;
   logic [7:0] tmr_load;
   logic run, hw_trigger_select, edge_hit, done, wr_any;
   logic [1:0] edge_sel;

   // trig_q resets low like the idle pin, so no false edge after reset
   function automatic logic edge_match(input logic [1:0] sel,
                                       input logic prev, input logic cur);
      case (sel)
         ADCSEQ_EDGE_FALL: edge_match = prev & ~cur;
         ADCSEQ_EDGE_RISE: edge_match = ~prev & cur;
         ADCSEQ_EDGE_BOTH: edge_match = prev ^ cur;
         default: edge_match = 1'b0;
      endcase
   endfunction

   assign run = mode_q[ADCSEQ_MODE_RUN_BIT];
   assign hw_trigger_select = mode_q[ADCSEQ_MODE_TRIG_BIT];
   assign edge_sel = {mode_q[ADCSEQ_MODE_EDGE_HI_BIT],
                      mode_q[ADCSEQ_MODE_EDGE_LO_BIT]};
   assign edge_hit = edge_match(edge_sel, trig_q, ext_trigger_pin);
   assign wr_any = mode_wr | chsel_wr;
   assign done = (st_q == ADCSEQ_CONV) && tick && bit_q[0] && !standby_stop;

   adcseq_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .restart(tmr_restart),
      .load_val(tmr_load),
      .run((st_q == ADCSEQ_STAB || st_q == ADCSEQ_CONV) && !standby_stop),
      .tick(tick)
   );

   // the start decision after writes uses the newly written mode value
   always_comb begin
      st_d = st_q;
      mode_d = mode_wr ? mode_wdata : mode_q;
      ch_d = chsel_wr ? chsel_wdata : ch_q;
      ref_d = ref_wr ? ref_wdata : ref_q;
      sar_d = sar_q;
      bit_d = bit_q;
      tmr_restart = 1'b0;
      tmr_load = ADCSEQ_BIT_CNT;
      // a write on the done cycle may latch a partial code; accepted
      if (wr_any) begin
         if (!mode_d[ADCSEQ_MODE_RUN_BIT]) begin
            st_d = ADCSEQ_IDLE;
         end else if (mode_d[ADCSEQ_MODE_TRIG_BIT]) begin
            st_d = ADCSEQ_WAIT;
         end else begin
            st_d = ADCSEQ_STAB;
         end
      end else if (!standby_stop) begin
         case (st_q)
            ADCSEQ_IDLE: begin
               if (run) begin
                  st_d = hw_trigger_select ? ADCSEQ_WAIT : ADCSEQ_STAB;
               end
            end
            ADCSEQ_WAIT: begin
               if (edge_hit) begin
                  st_d = ADCSEQ_STAB;
               end
            end
            ADCSEQ_STAB: begin
               st_d = ADCSEQ_STAB;
            end
            ADCSEQ_CONV: begin
               if (tick) begin
                  if (!comp_gt) begin
                     sar_d = sar_q & ~bit_q;
                  end
                  bit_d = bit_q >> 1;
                  sar_d = sar_d | (bit_q >> 1);
                  if (bit_q[0]) begin
                     st_d = hw_trigger_select ? ADCSEQ_WAIT : ADCSEQ_STAB;
                  end
               end
            end
            default: st_d = ADCSEQ_IDLE;
         endcase
      end
      // entering a conversion: load timer with optional stabilization
      if (st_d == ADCSEQ_STAB && st_q != ADCSEQ_STAB || (wr_any &&
          st_d == ADCSEQ_STAB)) begin
         tmr_restart = 1'b1;
         tmr_load = mode_d[ADCSEQ_MODE_CMPOFF_BIT] ? ADCSEQ_STAB_CNT
                                                   : 8'h00;
      end
      if (st_q == ADCSEQ_STAB && tick && !wr_any && !standby_stop) begin
         st_d = ADCSEQ_CONV;
         sar_d = ADCSEQ_SAR_MSB;
         bit_d = ADCSEQ_SAR_MSB;
      end
   end

   // result path: a read in the same cycle holds the write one cycle
   always_comb begin
      res_d = res_q;
      pend_d = pend_q;
      pend_v_d = pend_v_q;
      flag_d = flag_q;
      irq_d = 1'b0;
      if (flag_clr || irq_ack) begin
         flag_d = 1'b0;
      end
      if (done) begin
         flag_d = 1'b1;
         irq_d = 1'b1;
         if (result_rd) begin
            pend_d = sar_d;
            pend_v_d = 1'b1;
         end else begin
            res_d = sar_d;
         end
      end else if (pend_v_q) begin
         res_d = pend_q;
         pend_v_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= ADCSEQ_IDLE;
         mode_q <= ADCSEQ_MODE_RESET;
         ch_q <= ADCSEQ_CHSEL_RESET;
         ref_q <= 1'b0;
         sar_q <= 10'h000;
         bit_q <= 10'h000;
         res_q <= ADCSEQ_RESULT_RESET;
         pend_q <= 10'h000;
         pend_v_q <= 1'b0;
         flag_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         ch_q <= ch_d;
         ref_q <= ref_d;
         sar_q <= sar_d;
         bit_q <= bit_d;
         res_q <= res_d;
         pend_q <= pend_d;
         pend_v_q <= pend_v_d;
         flag_q <= flag_d;
         trig_q <= ext_trigger_pin;
      end
   end

   // outputs registered copies; mux follows the latched channel, 0 if beyond ADCSEQ_CH_MAX
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_mode_reg <= ADCSEQ_MODE_RESET;
         channel_select_reg <= ADCSEQ_CHSEL_RESET;
         conv_result_reg <= ADCSEQ_RESULT_RESET;
         conv_done_flag <= 1'b0;
         conv_done_irq <= 1'b0;
         conv_busy <= 1'b0;
         dac_code <= 10'h000;
         analog_mux_sel <= 4'h0;
         sample_hold <= 1'b0;
         comparator_off <= 1'b0;
         ref_switch_connect <= 1'b0;
      end else begin
         conv_mode_reg <= mode_d;
         channel_select_reg <= ch_d;
         conv_result_reg <= res_d;
         conv_done_flag <= flag_d;
         conv_done_irq <= irq_d;
         conv_busy <= (st_d == ADCSEQ_STAB) || (st_d == ADCSEQ_CONV);
         dac_code <= sar_d;
         analog_mux_sel <= (ch_d > ADCSEQ_CH_MAX) ? 4'h0 : ch_d;
         sample_hold <= (st_d == ADCSEQ_CONV);
         comparator_off <= mode_d[ADCSEQ_MODE_CMPOFF_BIT] &&
                           !mode_d[ADCSEQ_MODE_RUN_BIT];
         ref_switch_connect <= ref_d;
      end
   end

   // a read or write is assumed to take effect on its own strobe cycle
   run_stops_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_wr && !mode_wdata[ADCSEQ_MODE_RUN_BIT] |=> !conv_busy)
      else $error("conversion kept running after run cleared");
   sw_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_wr && mode_wdata[ADCSEQ_MODE_RUN_BIT] &&
      !mode_wdata[ADCSEQ_MODE_TRIG_BIT] |=> conv_busy)
      else $error("software start did not begin");
   hw_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_wr && mode_wdata[ADCSEQ_MODE_RUN_BIT] &&
      mode_wdata[ADCSEQ_MODE_TRIG_BIT] |=> !conv_busy)
      else $error("trigger-mode write did not abort");
   done_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
      conv_done_irq |-> conv_done_flag)
      else $error("done request without flag");
   flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      conv_done_flag && !flag_clr && !irq_ack |=> conv_done_flag)
      else $error("done flag dropped without clear");
   chsel_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      chsel_wr && flag_q && !flag_clr && !irq_ack |=> conv_done_flag)
      else $error("channel write cleared done flag");
   read_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      done && result_rd |=> $stable(res_q) ##1 (res_q == $past(sar_d, 2)))
      else $error("result write not deferred behind read");
   standby_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      standby_stop && !wr_any |=> $stable(sar_q))
      else $error("converter advanced in standby");
   hw_once_a: assert property (@(posedge clk) disable iff (!rst_n)
      done && hw_trigger_select && !wr_any |=> st_q == ADCSEQ_WAIT)
      else $error("trigger mode did not wait after conversion");
   res_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
      !done && !pend_v_q |=> $stable(res_q))
      else $error("result changed without completion");
   sar_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ADCSEQ_STAB && tick && !wr_any && !standby_stop
      |=> sar_q == ADCSEQ_SAR_MSB)
      else $error("approximation did not start at msb");
   wait_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ADCSEQ_WAIT && !edge_hit && !wr_any |=> st_q == ADCSEQ_WAIT)
      else $error("left trigger wait without an edge");
   conv_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ADCSEQ_CONV && !tick && !wr_any |=> st_q == ADCSEQ_CONV)
      else $error("conversion disturbed between bit steps");
   mux_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      analog_mux_sel <= ADCSEQ_CH_MAX)
      else $error("mux select beyond last channel");
   sw_done_c: cover property (@(posedge clk) disable iff (!rst_n)
      done && !hw_trigger_select);
   hw_done_c: cover property (@(posedge clk) disable iff (!rst_n)
      done && hw_trigger_select);
   rd_clash_c: cover property (@(posedge clk) disable iff (!rst_n)
      done && result_rd);
   abort_c: cover property (@(posedge clk) disable iff (!rst_n)
      mode_wr && conv_busy && mode_wdata[ADCSEQ_MODE_TRIG_BIT]);
   standby_c: cover property (@(posedge clk) disable iff (!rst_n)
      standby_stop && st_q == ADCSEQ_CONV);
endmodule // adcseq_core

// *** adcseq_pkg.sv ***
package adcseq_pkg;
   localparam int ADCSEQ_RES_BITS = 10;
   localparam int ADCSEQ_NUM_CH = 12;
   localparam logic [3:0] ADCSEQ_CH_MAX = 4'hB;
   localparam int ADCSEQ_MODE_RUN_BIT = 7;
   localparam int ADCSEQ_MODE_TRIG_BIT = 6;
   localparam int ADCSEQ_MODE_EDGE_HI_BIT = 3;
   localparam int ADCSEQ_MODE_EDGE_LO_BIT = 2;
   localparam int ADCSEQ_MODE_CMPOFF_BIT = 0;
   localparam logic [7:0] ADCSEQ_MODE_RESET = 8'h00;
   localparam logic [3:0] ADCSEQ_CHSEL_RESET = 4'h0;
   localparam logic [9:0] ADCSEQ_RESULT_RESET = 10'h000;
   localparam logic [9:0] ADCSEQ_SAR_MSB = 10'h200;
   localparam logic [1:0] ADCSEQ_EDGE_NONE = 2'h0;
   localparam logic [1:0] ADCSEQ_EDGE_FALL = 2'h1;
   localparam logic [1:0] ADCSEQ_EDGE_RISE = 2'h2;
   localparam logic [1:0] ADCSEQ_EDGE_BOTH = 2'h3;
   localparam int ADCSEQ_CLK_MHZ = 25;
   localparam int ADCSEQ_BIT_TIME_NS = 400;
   localparam int ADCSEQ_BIT_CYC = (ADCSEQ_BIT_TIME_NS * ADCSEQ_CLK_MHZ) / 1000;
   localparam int ADCSEQ_STAB_TIME_NS = 3000;
   localparam int ADCSEQ_STAB_CYC = (ADCSEQ_STAB_TIME_NS * ADCSEQ_CLK_MHZ) / 1000;
   localparam logic [7:0] ADCSEQ_BIT_CNT = 8'(ADCSEQ_BIT_CYC - 1);
   localparam logic [7:0] ADCSEQ_STAB_CNT = 8'(ADCSEQ_STAB_CYC);
   typedef enum logic [1:0] {
      ADCSEQ_IDLE = 2'b00,
      ADCSEQ_WAIT = 2'b01,
      ADCSEQ_STAB = 2'b10,
      ADCSEQ_CONV = 2'b11
   } adcseq_state_t;
endpackage

// *** adcseq_timer.sv ***
`timescale 1ns/10ps
module adcseq_timer
   import adcseq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic [7:0] load_val,
   input wire logic run,
   output logic tick
);
   logic [7:0] cnt_q, cnt_d;
   logic tick_d;
   always_comb begin
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (restart) begin
         cnt_d = load_val;
      end else if (run) begin
         if (cnt_q == 8'h00) begin
            tick_d = 1'b1;
            cnt_d = ADCSEQ_BIT_CNT;
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick <= tick_d;
      end
   end
endmodule // adcseq_timer

// *** adcseq_analog_model.sv ***
`timescale 1ns/10ps
module adcseq_analog_model
   import adcseq_pkg::*;
(
   input wire logic [9:0] dac_code,
   input wire logic [3:0] analog_mux_sel,
   output logic comp_gt
);
   // input levels in half-lsb steps, loaded by the bench
   logic [10:0] vin2 [ADCSEQ_NUM_CH];
   // tap sits half an lsb below the trial code so results come out rounded
   assign comp_gt = {1'b0, vin2[analog_mux_sel]} >=
                    {1'b0, dac_code, 1'b0} - 12'h001;
endmodule // adcseq_analog_model

// *** adc_conversion_sequencer_tb.sv ***
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
   import adcseq_pkg::*;
   logic clk, rst_n, mode_wr, chsel_wr, ref_wr, ref_wdata, result_rd;
   logic flag_clr, irq_ack, standby_stop, ext_trigger_pin, comp_gt;
   logic [7:0] mode_wdata, conv_mode_reg;
   logic [3:0] chsel_wdata, channel_select_reg, analog_mux_sel;
   logic [9:0] conv_result_reg, dac_code;
   logic conv_done_flag, conv_done_irq, conv_busy, sample_hold;
   logic comparator_off, ref_switch_connect, got;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc, t0;

   adcseq_core adcseq_core_inst (
      .clk(clk), .rst_n(rst_n), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .chsel_wr(chsel_wr), .chsel_wdata(chsel_wdata), .ref_wr(ref_wr),
      .ref_wdata(ref_wdata), .result_rd(result_rd), .flag_clr(flag_clr),
      .irq_ack(irq_ack), .standby_stop(standby_stop),
      .ext_trigger_pin(ext_trigger_pin), .comp_gt(comp_gt),
      .conv_mode_reg(conv_mode_reg), .channel_select_reg(channel_select_reg),
      .conv_result_reg(conv_result_reg), .conv_done_flag(conv_done_flag),
      .conv_done_irq(conv_done_irq), .conv_busy(conv_busy),
      .dac_code(dac_code), .analog_mux_sel(analog_mux_sel),
      .sample_hold(sample_hold), .comparator_off(comparator_off),
      .ref_switch_connect(ref_switch_connect));

   adcseq_analog_model ana (
      .dac_code(dac_code), .analog_mux_sel(analog_mux_sel), .comp_gt(comp_gt));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic finish_test();
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [9:0] e, logic [9:0] s);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, e, s);
      end
   endtask

   // rounded code for a level given in half-lsb steps
   function automatic logic [9:0] exp_code(input logic [10:0] v2);
      logic [11:0] r;
      r = ({1'b0, v2} + 12'h001) >> 1;
      return (r > 12'h3FF) ? 10'h3FF : r[9:0];
   endfunction

   task automatic wr_mode(input logic [7:0] v);
      mode_wdata = v;
      mode_wr = 1'b1;
      @(negedge clk);
      mode_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic wr_chsel(input logic [3:0] v);
      chsel_wdata = v;
      chsel_wr = 1'b1;
      @(negedge clk);
      chsel_wr = 1'b0;
   endtask

   task automatic clear_flag(input logic by_ack);
      flag_clr = ~by_ack;
      irq_ack = by_ack;
      @(negedge clk);
      {flag_clr, irq_ack} = 2'b00;
      chk("flag clear", 10'h000, 10'(conv_done_flag));
   endtask

   task automatic wait_irq(input int lim);
      got = 1'b0;
      for (cyc = 1; cyc <= lim && !got; cyc++) begin
         @(negedge clk);
         got = (conv_done_irq === 1'b1);
      end
   endtask

   task automatic expect_conv(input logic [3:0] ch);
      wait_irq(300);
      if (!got) begin
         chk("done irq", 10'h001, 10'(got));
         finish_test();
      end
      chk("result", exp_code(ana.vin2[ch]), conv_result_reg);
      chk("trial code", exp_code(ana.vin2[ch]), dac_code);
      chk("flag set", 10'h001, 10'(conv_done_flag));
   endtask

   task automatic expect_none(input string what);
      wait_irq(300);
      chk(what, 10'h000, 10'(got));
   endtask

   // edges are only toggled when a conversion is expected, else they count
   task automatic trig_case(input logic e);
      if (e) begin
         repeat (20) @(negedge clk);
         ext_trigger_pin = ~ext_trigger_pin;
         @(negedge clk);
         ext_trigger_pin = ~ext_trigger_pin;
      end
      wait_irq(300);
      chk("trigger", 10'(e), 10'(got));
      expect_none("one shot");
   endtask

   initial begin
      {rst_n, mode_wr, chsel_wr, ref_wr, ref_wdata, result_rd} = '0;
      {flag_clr, irq_ack, standby_stop, ext_trigger_pin} = '0;
      mode_wdata = 8'h00;
      chsel_wdata = 4'h0;
      void'($urandom(32'hB771));
      for (int i = 0; i < ADCSEQ_NUM_CH; i++) ana.vin2[i] = 11'($urandom_range(2046));
      ana.vin2[0] = 11'h000;
      ana.vin2[11] = 11'h7FE;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      chk("result reset", 10'h000, conv_result_reg);
      ref_wdata = 1'b1;
      ref_wr = 1'b1;
      @(negedge clk);
      ref_wr = 1'b0;
      chk("ref switch", 10'h001, 10'(ref_switch_connect));
      for (int c = 0; c < ADCSEQ_NUM_CH; c++) begin
         repeat (5) @(negedge clk);
         wr_chsel(4'(c));
         chk("channel", 10'(c), 10'(channel_select_reg));
         chk("mux", 10'(c), 10'(analog_mux_sel));
         if (c > 0) chk("flag kept", 10'h001, 10'(conv_done_flag));
         if (c == 0) wr_mode(8'h80);
         if (c == 0) chk("mode reg", 10'h080, 10'(conv_mode_reg));
         expect_conv(4'(c));
         expect_conv(4'(c));
      end
      clear_flag(1'b1);
      repeat (5) @(negedge clk);
      wr_mode(8'h00);
      expect_none("stop");
      chk("busy", 10'h000, 10'(conv_busy));
      clear_flag(1'b0);
      wr_mode(8'h80);
      expect_conv(4'hB);
      t0 = cyc;
      wr_mode(8'h00);
      wr_mode(8'h81);
      expect_conv(4'hB);
      chk("stab time", 10'(ADCSEQ_STAB_CYC), 10'(cyc - t0));
      wr_mode(8'h01);
      chk("comp off", 10'h001, 10'(comparator_off));
      wr_mode(8'h00);
      repeat (125) @(negedge clk);
      wr_mode(8'h80);
      repeat (20) @(negedge clk);
      standby_stop = 1'b1;
      expect_none("standby");
      chk("held", 10'h001, 10'(sample_hold));
      standby_stop = 1'b0;
      expect_conv(4'hB);
      repeat (5) @(negedge clk);
      result_rd = 1'b1;
      ana.vin2[11] = 11'($urandom_range(2046));
      wr_chsel(4'hB);
      wait_irq(300);
      chk("read first", exp_code(11'h7FE), conv_result_reg);
      @(negedge clk);
      chk("deferred", exp_code(ana.vin2[11]), conv_result_reg);
      result_rd = 1'b0;
      for (int e = 0; e < 4; e++) begin
         wr_mode(8'h00);
         clear_flag(1'b0);
         wr_mode(8'hC0 | 8'(e << 2));
         expect_none("trigger wait");
         ext_trigger_pin = 1'b1;
         trig_case(e[1]);
         ext_trigger_pin = 1'b0;
         trig_case(e[0]);
      end
      wr_mode(8'hC8);
      ext_trigger_pin = 1'b1;
      repeat (20) @(negedge clk);
      wr_mode(8'hC8);
      expect_none("abort");
      ext_trigger_pin = 1'b0;
      @(negedge clk);
      ext_trigger_pin = 1'b1;
      expect_conv(4'hB);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk("result cleared", 10'h000, conv_result_reg);
      finish_test();
   end
endmodule // adc_conversion_sequencer_tb
